// >>> encp_top.v
// Encoder position output: zeroing, quadrature, reference mark and serial port
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "encp_consts.vh"

module encp_top #(
    parameter MONO_CYC = `ENCP_MONO_CYC
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Interpolated angle
    input wire [11:0] abs_pos,
    // Zero pin
    input wire zero_pin,
    // Serial port
    input wire ssi_clk,
    output reg ssi_data,
    // Incremental outputs
    output reg quad_a,
    output reg quad_b,
    output reg ref_mark
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    // Serial frame phases
    localparam [1:0] PH_BIT = 2'h0;
    localparam [1:0] PH_GAP = 2'h1;
    localparam [1:0] PH_AFTER = 2'h2;

    // Mask of the position bits kept at a given resolution code
    function [11:0] res_mask;
        input [2:0] res;
        begin
            res_mask = ~((12'h001 << res) - 12'h001);
        end
    endfunction

    // Serial frame length in bits
    function [3:0] frame_len;
        input ring;
        input [2:0] res;
        begin
            if (ring)
                frame_len = 4'hC - {1'b0, res};
            else
                frame_len = 4'hC;
        end
    endfunction

    // Where the bit counter stands within a frame of the given length
    function [1:0] ssi_phase;
        input [3:0] cnt;
        input [3:0] len;
        begin
            if (cnt < len)
                ssi_phase = PH_BIT;
            else if (cnt == len)
                ssi_phase = PH_GAP;
            else
                ssi_phase = PH_AFTER;
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg [5:0] ctrl;
    reg [11:0] zero_pos;
    wire dir_neg;
    wire [2:0] res_code;
    wire [1:0] ring_cfg;
    wire ring_on;
    wire ring_fresh;
    wire [11:0] rel_pos;
    wire [11:0] out_pos;
    wire [11:0] step_pos;
    wire [11:0] ssi_word;
    wire [3:0] flen;
    wire [1:0] pin_level;
    wire [1:0] pin_rise;
    wire [1:0] pin_fall;
    wire zero_rise;
    wire sclk_rise;
    wire sclk_fall;
    wire sclk_edge;
    reg mono_on;
    reg [15:0] mono_cnt;
    reg [11:0] ssi_shreg;
    reg [3:0] bit_cnt;
    wire [3:0] bit_idx;
    wire [1:0] frame_phase;
    reg [31:0] next_rdata;

    // ----------------------------------------------------------------
    // Pin synchronisers (bit 1 serial clock idles high)
    // ----------------------------------------------------------------
    encp_sync_edge #(
        .N(2),
        .IDLE(2'h2)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in({ssi_clk, zero_pin}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign zero_rise = pin_rise[0];
    assign sclk_rise = pin_rise[1];
    assign sclk_fall = pin_fall[1];
    assign sclk_edge = sclk_rise | sclk_fall;

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    assign dir_neg = ctrl[`ENCP_CTRL_SIGN];
    assign res_code = ctrl[`ENCP_CTRL_RES_MSB:`ENCP_CTRL_RES_LSB];
    assign ring_cfg = ctrl[`ENCP_CTRL_RING_MSB:`ENCP_CTRL_RING_LSB];
    assign ring_on = (ring_cfg == `ENCP_RING_REPEAT) || ring_fresh;
    assign ring_fresh = (ring_cfg == `ENCP_RING_REFRESH);

    // ----------------------------------------------------------------
    // Position arithmetic
    // ----------------------------------------------------------------
    // Absolute input is never altered; only the relative copy sees zero
    assign rel_pos = abs_pos - zero_pos;

    // Negative direction counts the other way round the turn
    assign out_pos = dir_neg ? (12'h000 - rel_pos) : rel_pos;

    // Step count at the selected interpolation rate
    assign step_pos = out_pos >> res_code;

    // Serial word keeps only the bits of the selected rate, MSB aligned
    assign ssi_word = out_pos & res_mask(res_code);

    assign flen = frame_len(ring_on, res_code);

    assign bit_idx = 4'hB - bit_cnt;

    assign frame_phase = ssi_phase(bit_cnt, flen);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl <= `ENCP_CTRL_RST;
        else if (reg_wr && (reg_addr == `ENCP_ADDR_CTRL))
            ctrl <= reg_wdata[5:0];
    end

    // ----------------------------------------------------------------
    // Zero register
    // ----------------------------------------------------------------
    // The pin edge wins over a software write in the same cycle
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            zero_pos <= `ENCP_ZERO_RST;
        else if (zero_rise)
            zero_pos <= abs_pos;
        else if (reg_wr && (reg_addr == `ENCP_ADDR_ZERO))
            zero_pos <= reg_wdata[11:0];
    end

    // ----------------------------------------------------------------
    // Incremental outputs
    // ----------------------------------------------------------------
    // Gray sequence 00,01,11,10 on (A,B) as steps rise: B leads A
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            quad_a <= 1'b0;
            quad_b <= 1'b0;
            ref_mark <= 1'b0;
        end
        else
        begin
            quad_a <= step_pos[1];
            quad_b <= step_pos[1] ^ step_pos[0];
            // One step wide at zero: a quarter of the A/B period
            ref_mark <= (step_pos == 12'h000);
        end
    end

    // ----------------------------------------------------------------
    // Monoflop
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mono_on <= 1'b0;
            mono_cnt <= 16'h0000;
        end
        else if (!mono_on)
        begin
            if (sclk_fall)
            begin
                mono_on <= 1'b1;
                mono_cnt <= MONO_CYC[15:0];
            end
        end
        else if (sclk_edge)
            mono_cnt <= MONO_CYC[15:0];
        else if (mono_cnt <= 16'h0001)
        begin
            mono_on <= 1'b0;
            mono_cnt <= 16'h0000;
        end
        else
            mono_cnt <= mono_cnt - 16'h0001;
    end

    // ----------------------------------------------------------------
    // Serial shift register and bit counter
    // ----------------------------------------------------------------
    // bit_cnt runs 0..flen while sending; flen+1 marks the gap bit sent
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ssi_shreg <= 12'h000;
            bit_cnt <= 4'h0;
        end
        else if (!mono_on)
        begin
            if (sclk_fall)
            begin
                ssi_shreg <= ssi_word;
                bit_cnt <= 4'h0;
            end
        end
        else if (sclk_rise)
        begin
            if (frame_phase == PH_BIT)
                bit_cnt <= bit_cnt + 4'h1;
            else if (frame_phase == PH_GAP)
            begin
                bit_cnt <= flen + 4'h1;
                if (ring_fresh)
                    ssi_shreg <= ssi_word;
            end
            else if (ring_on)
                bit_cnt <= 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Serial data line
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ssi_data <= 1'b1;
        else if (!mono_on)
            ssi_data <= 1'b1;
        else if (!sclk_edge && (mono_cnt <= 16'h0001))
            ssi_data <= 1'b1;
        else if (sclk_rise)
        begin
            if (frame_phase == PH_BIT)
                ssi_data <= ssi_shreg[bit_idx];
            else if (frame_phase == PH_GAP)
                ssi_data <= 1'b0;
            else if (ring_on)
                ssi_data <= ssi_shreg[11];
            else
                ssi_data <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            `ENCP_ADDR_CTRL:
                next_rdata = {26'h000_0000, ctrl};
            `ENCP_ADDR_ZERO:
                next_rdata = {20'h0_0000, zero_pos};
            `ENCP_ADDR_RELPOS:
                next_rdata = {20'h0_0000, rel_pos};
            `ENCP_ADDR_ABSPOS:
                next_rdata = {20'h0_0000, abs_pos};
            `ENCP_ADDR_OUTPOS:
                next_rdata = {20'h0_0000, step_pos};
            `ENCP_ADDR_STATUS:
                next_rdata = {26'h000_0000, pin_level[1], mono_on, bit_cnt};
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 32'h0000_0000;
    end

endmodule // encp_top

// >>> encp_consts.vh
// Constants for the encoder position output block
`ifndef ENCP_CONSTS_VH
`define ENCP_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ENCP_ADDR_CTRL 8'h00
`define ENCP_ADDR_ZERO 8'h04
`define ENCP_ADDR_RELPOS 8'h08
`define ENCP_ADDR_ABSPOS 8'h0C
`define ENCP_ADDR_OUTPOS 8'h10
`define ENCP_ADDR_STATUS 8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ENCP_CTRL_SIGN 0
`define ENCP_CTRL_RES_LSB 1
`define ENCP_CTRL_RES_MSB 3
`define ENCP_CTRL_RING_LSB 4
`define ENCP_CTRL_RING_MSB 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ENCP_CTRL_RST 6'h00
`define ENCP_ZERO_RST 12'h000

// ----------------------------------------------------------------
// Serial configuration codes
// ----------------------------------------------------------------
`define ENCP_RING_REPEAT 2'h1
`define ENCP_RING_REFRESH 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ENCP_CLK_MHZ 10
`define ENCP_TMONO_US 19
`define ENCP_MONO_CYC (`ENCP_TMONO_US * `ENCP_CLK_MHZ)

`endif

// >>> encp_sync_edge.v
// Two-flop synchronisers with edge detection for external pins
`timescale 1ns/1ps

module encp_sync_edge #(
    parameter N = 2,
    parameter [N-1:0] IDLE = {N{1'b0}}
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Asynchronous pins
    input wire [N-1:0] pin_in,
    // Synchronised level and edges
    output wire [N-1:0] level,
    output wire [N-1:0] rise,
    output wire [N-1:0] fall
);

    // ----------------------------------------------------------------
    // Per-pin synchroniser
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : g_sync
            reg stage1;
            reg stage2;
            reg stage3;
            always @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    stage1 <= IDLE[i];
                    stage2 <= IDLE[i];
                    stage3 <= IDLE[i];
                end
                else
                begin
                    stage1 <= pin_in[i];
                    stage2 <= stage1;
                    stage3 <= stage2;
                end
            end
            assign level[i] = stage2;
            assign rise[i] = stage2 & ~stage3;
            assign fall[i] = ~stage2 & stage3;
        end
    endgenerate

endmodule // encp_sync_edge

// >>> encp_assertions.sv
// Assertion checker for the encoder position output block
`timescale 1ns/1ps
`include "encp_consts.vh"
module encp_top_chk #(
    parameter MONO_CYC = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Pins
    input wire [11:0] abs_pos,
    input wire zero_pin,
    input wire ssi_clk,
    input wire ssi_data,
    input wire quad_a,
    input wire quad_b,
    input wire ref_mark
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // Cycles since the serial clock last moved
    logic [7:0] idle_cnt;
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            idle_cnt <= 8'h00;
        else if ($changed(ssi_clk))
            idle_cnt <= 8'h00;
        else if (idle_cnt != 8'hff)
            idle_cnt <= idle_cnt + 8'h01;
    sequence s_quiet;
        $stable(abs_pos) && !reg_wr && $stable(zero_pin);
    endsequence
    sequence s_pin_zero;
        $rose(zero_pin) ##1 ($stable(abs_pos) && !reg_wr)[*6];
    endsequence
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    property p_out_width;
        reg_rd && reg_addr == `ENCP_ADDR_OUTPOS |=> reg_rdata[31:12] == 20'h0_0000;
    endproperty
    property p_ref_ab;
        ref_mark |-> !quad_a && !quad_b;
    endproperty
    property p_one_step;
        (abs_pos - $past(abs_pos)) == 12'h001 && !reg_wr && !$past(reg_wr)
            |=> !($changed(quad_a) && $changed(quad_b));
    endproperty
    property p_quiet;
        s_quiet[*6] |-> $stable(quad_a) && $stable(quad_b) && $stable(ref_mark);
    endproperty
    property p_pin_zero;
        s_pin_zero |-> ref_mark;
    endproperty
    property p_data_high;
        $changed(ssi_data) |-> $past(ssi_clk, 3);
    endproperty
    property p_expiry;
        idle_cnt == 8'(MONO_CYC + 8) |-> ssi_data;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    a_out_width: assert property (p_out_width) else $error("position wider than 12 bits");
    a_ref_ab: assert property (p_ref_ab) else $error("mark not aligned to A and B");
    a_one_step: assert property (p_one_step) else $error("A and B moved together");
    a_quiet: assert property (p_quiet) else $error("outputs moved with inputs still");
    a_pin_zero: assert property (p_pin_zero) else $error("zero pin did not zero");
    a_data_high: assert property (p_data_high) else $error("data moved off a rise");
    a_expiry: assert property (p_expiry) else $error("data not high after idle");
endmodule // encp_top_chk
bind encp_top encp_top_chk #(.MONO_CYC(MONO_CYC)) u_encp_top_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .abs_pos(abs_pos), .zero_pin(zero_pin),
    .ssi_clk(ssi_clk), .ssi_data(ssi_data), .quad_a(quad_a), .quad_b(quad_b),
    .ref_mark(ref_mark)
);

// >>> encp_ssi_master.sv
// Serial position reader standing in for the external controller
`timescale 1ns/1ps
module encp_ssi_master #(
    parameter int MONO = 8
) (
    // Bench clock
    input wire sys_clk,
    // Serial link
    output logic ssi_clk,
    input wire ssi_data
);
    initial ssi_clk = 1'b1;
    // Bit k is taken two cycles into the following low phase, where it is settled
    task automatic read(input int n, output logic [31:0] bits);
        bits = 32'h0000_0000;
        @(posedge sys_clk);
        for (int i = 0; i <= n; i++)
        begin
            if (i < n)
                ssi_clk <= 1'b0;
            repeat (2) @(posedge sys_clk);
            if (i > 0)
                bits = {bits[30:0], ssi_data};
            repeat (2) @(posedge sys_clk);
            if (i < n)
                ssi_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
        repeat (MONO + 8) @(posedge sys_clk);
    endtask
endmodule // encp_ssi_master

// >>> tb_top.sv
// Self-checking testbench for the encoder position output block
`timescale 1ns/1ps
`include "encp_consts.vh"
module tb_top;
    localparam int MONO = 8;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] abs_pos = 12'h000;
    logic zero_pin = 1'b0;
    wire [31:0] reg_rdata;
    wire ssi_clk;
    wire ssi_data;
    wire quad_a;
    wire quad_b;
    wire ref_mark;
    int fails = 0;
    int num_checks = 0;
    encp_top #(.MONO_CYC(MONO)) u_encp_top (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .abs_pos(abs_pos),
        .zero_pin(zero_pin), .ssi_clk(ssi_clk), .ssi_data(ssi_data), .quad_a(quad_a),
        .quad_b(quad_b), .ref_mark(ref_mark)
    );
    encp_ssi_master #(.MONO(MONO)) u_encp_ssi_master (
        .sys_clk(sys_clk), .ssi_clk(ssi_clk), .ssi_data(ssi_data)
    );
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        cmp(reg_rdata, e, what);
    endtask
    task automatic ctrl(input logic [1:0] ring, input logic [2:0] res, input logic sgn);
        wr(`ENCP_ADDR_CTRL, {26'h0, ring, res, sgn});
    endtask
    task automatic t_regs();
        rd(`ENCP_ADDR_CTRL, 32'h0000_0000, "ctrl reset");
        rd(`ENCP_ADDR_ZERO, 32'h0000_0000, "zero reset");
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0000_0000, "unmapped");
        abs_pos <= 12'h005;
        wr(`ENCP_ADDR_ZERO, 32'h0000_000a);
        rd(`ENCP_ADDR_ZERO, 32'h0000_000a, "zero write");
        rd(`ENCP_ADDR_RELPOS, 32'h0000_0ffb, "relative wrap");
        rd(`ENCP_ADDR_ABSPOS, 32'h0000_0005, "absolute kept");
        $display("test regs done");
    endtask
    task automatic t_zero_pin();
        abs_pos <= 12'h123;
        repeat (3) @(posedge sys_clk);
        zero_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        cmp(ref_mark, 32'h0000_0001, "mark at zero");
        zero_pin <= 1'b0;
        rd(`ENCP_ADDR_ZERO, 32'h0000_0123, "pin zero");
        rd(`ENCP_ADDR_RELPOS, 32'h0000_0000, "relative zero");
        rd(`ENCP_ADDR_ABSPOS, 32'h0000_0123, "absolute kept");
        $display("test zero pin done");
    endtask
    task automatic t_quad();
        wr(`ENCP_ADDR_ZERO, 32'h0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            abs_pos <= 12'(i);
            repeat (3) @(posedge sys_clk);
            cmp({quad_a, quad_b, ref_mark}, {i[1], i[1] ^ i[0], i == 0}, "quad");
        end
        ctrl(2'b00, 3'b000, 1'b1);
        abs_pos <= 12'h001;
        repeat (3) @(posedge sys_clk);
        cmp({quad_a, quad_b, ref_mark}, 32'h0000_0004, "reversed quad");
        rd(`ENCP_ADDR_OUTPOS, 32'h0000_0fff, "reversed count");
        abs_pos <= 12'hfff;
        for (int r = 0; r < 8; r++)
        begin
            ctrl(2'b00, 3'(r), 1'b0);
            rd(`ENCP_ADDR_OUTPOS, 32'h0000_0fff >> r, "rate");
        end
        $display("test quadrature done");
    endtask
    task automatic t_ssi();
        logic [31:0] bits;
        logic [31:0] exp_bits;
        for (int m = 0; m < 4; m++)
        begin
            ctrl(2'(m), 3'b100, 1'b0);
            abs_pos <= 12'ha5c;
            fork
                u_encp_ssi_master.read(17, bits);
                begin
                    repeat (40) @(posedge sys_clk);
                    abs_pos <= 12'h3c7;
                end
            join
            if (m == 1)
                exp_bits = {15'h0000, 8'ha5, 1'b0, 8'ha5};
            else if (m == 3)
                exp_bits = {15'h0000, 8'ha5, 1'b0, 8'h3c};
            else
                exp_bits = {15'h0000, 12'ha50, 5'h00};
            cmp(bits, exp_bits, "frame");
            cmp(ssi_data, 32'h0000_0001, "idle high");
        end
        $display("test serial done");
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_zero_pin();
        t_quad();
        t_ssi();
        report_and_stop();
    end
endmodule // tb_top
